/* File: pfs_port_e_mux.sv */
// Pin function select for port E pins 5 and 11, direction control for pins 0..15.
// Assumes pins sit outside the clock domain; pin inputs are synchronised.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module pfs_port_e_mux
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port data register, set by other logic on mclk
  input wire logic [15:0] port_out_data,
  output logic [15:0] port_in_data,
  // Serial interface
  input wire logic serial_transmit_line,
  output logic serial_receive_line,
  // Pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);
  //////////////////////////////////////////////////////////////////////////////
  logic [15:0] port_e_direction_low;
  logic [15:0] port_e_function_select_pins_4_to_7;
  logic [15:0] port_e_function_select_pins_8_to_11;
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [2:0] pin5_function_code;
  logic [2:0] pin11_function_code;
  logic tx_sel;
  logic rx_sel;
  logic rd_done;
  pfs_pkg::pfs_drive_s drive;

  // Pulls one 3-bit code out of a select register
  function automatic logic [2:0] field_code(input logic [15:0] sel, input int lsb);
    return sel[lsb +: pfs_pkg::FIELD_W];
  endfunction

  // Registers sit in the low half of each bus word
  function automatic logic [31:0] bus_word(input logic [15:0] value);
    return {16'h0000, value};
  endfunction

  assign pin5_function_code =
    field_code(port_e_function_select_pins_4_to_7, pfs_pkg::TX_FIELD_LSB);
  assign pin11_function_code =
    field_code(port_e_function_select_pins_8_to_11, pfs_pkg::RX_FIELD_LSB);

  //////////////////////////////////////////////////////////////////////////////
  // Register writes; select writes store only code bits so gap bits stay zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      port_e_direction_low <= pfs_pkg::RST_DIR;
      port_e_function_select_pins_4_to_7 <= pfs_pkg::RST_SEL;
      port_e_function_select_pins_8_to_11 <= pfs_pkg::RST_SEL;
    end
    else if (write)
    begin
      case (address)
        pfs_pkg::ADDR_DIR: port_e_direction_low <= writedata[15:0];
        pfs_pkg::ADDR_SEL_LO:
          port_e_function_select_pins_4_to_7 <= writedata[15:0] & pfs_pkg::SEL_WMASK;
        pfs_pkg::ADDR_SEL_HI:
          port_e_function_select_pins_8_to_11 <= writedata[15:0] & pfs_pkg::SEL_WMASK;
        default: ;
      endcase
    end
  end

  // Reads take one wait cycle so readdata comes from a flip-flop
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rd_done <= 1'b0;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_done <= read && !rd_done;
      if (read && !rd_done)
      begin
        case (address)
          pfs_pkg::ADDR_DIR: readdata <= bus_word(port_e_direction_low);
          pfs_pkg::ADDR_SEL_LO: readdata <= bus_word(port_e_function_select_pins_4_to_7);
          pfs_pkg::ADDR_SEL_HI: readdata <= bus_word(port_e_function_select_pins_8_to_11);
          pfs_pkg::ADDR_PIN_IN: readdata <= bus_word(pin_sync);
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign waitrequest = read && !rd_done;

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser on the pins
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Codes other than the serial ones fall back to the port
  assign tx_sel = (pin5_function_code == pfs_pkg::FN_TX);
  // Receive pin is only honoured as input, so software must clear its direction
  assign rx_sel = (pin11_function_code == pfs_pkg::FN_RX)
                  && !port_e_direction_low[pfs_pkg::RX_PIN];

  always_comb
  begin
    drive.out_data = port_out_data;
    drive.out_en = port_e_direction_low;
    if (tx_sel)
    begin
      drive.out_data[pfs_pkg::TX_PIN] = serial_transmit_line;
      drive.out_en[pfs_pkg::TX_PIN] = port_e_direction_low[pfs_pkg::TX_PIN];
    end
    if (rx_sel)
      drive.out_en[pfs_pkg::RX_PIN] = 1'b0;
  end

  assign pin_out = drive.out_data;
  assign pin_oe = drive.out_en;
  assign port_in_data = pin_sync;
  // Idle high when not routed, so the serial receiver sees a marking line
  assign serial_receive_line = rx_sel ? pin_sync[pfs_pkg::RX_PIN] : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Pin side, plus the select gap bits
  AST_DIR_OE: assert property (@(posedge mclk) disable iff (reset)
    !(tx_sel || rx_sel) |-> pin_oe == port_e_direction_low)
    else $error("pin enable differs from direction");
  AST_TX_OE: assert property (@(posedge mclk) disable iff (reset)
    tx_sel |-> pin_oe[pfs_pkg::TX_PIN] == port_e_direction_low[pfs_pkg::TX_PIN])
    else $error("transmit pin enable differs from direction");
  AST_RX_INPUT: assert property (@(posedge mclk) disable iff (reset)
    rx_sel |-> !pin_oe[pfs_pkg::RX_PIN])
    else $error("receive pin driven");
  AST_RX_HELD_OFF: assert property (@(posedge mclk) disable iff (reset)
    (pin11_function_code == pfs_pkg::FN_RX && port_e_direction_low[pfs_pkg::RX_PIN])
    |-> serial_receive_line && pin_oe[pfs_pkg::RX_PIN])
    else $error("receive routed while pin is an output");
  AST_GAP_ZERO: assert property (@(posedge mclk) disable iff (reset)
    ((port_e_function_select_pins_4_to_7 | port_e_function_select_pins_8_to_11)
     & ~pfs_pkg::SEL_WMASK) == 16'h0000)
    else $error("reserved select bit set");
  AST_PORT_DATA: assert property (@(posedge mclk) disable iff (reset)
    !tx_sel |-> pin_out == port_out_data)
    else $error("port data not on pins");
  AST_PIN_SYNC: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2)) |-> port_in_data == $past(pin_in, 2))
    else $error("pin level not passed through two stages");
  AST_TX_ROUTE: assert property (@(posedge mclk) disable iff (reset)
    pin5_function_code == pfs_pkg::FN_TX |-> pin_out[pfs_pkg::TX_PIN] == serial_transmit_line)
    else $error("transmit not routed");
  AST_RX_ROUTE: assert property (@(posedge mclk) disable iff (reset)
    (pin11_function_code == pfs_pkg::FN_RX && !port_e_direction_low[pfs_pkg::RX_PIN])
    |-> serial_receive_line == pin_sync[pfs_pkg::RX_PIN])
    else $error("receive not routed");
  AST_RX_IDLE: assert property (@(posedge mclk) disable iff (reset)
    pin11_function_code != pfs_pkg::FN_RX |-> serial_receive_line)
    else $error("receive not idle");
  AST_TX_IDLE_PORT: assert property (@(posedge mclk) disable iff (reset)
    pin5_function_code != pfs_pkg::FN_TX
    |-> pin_out[pfs_pkg::TX_PIN] == port_out_data[pfs_pkg::TX_PIN])
    else $error("undefined transmit code left the port");
  // Reset is sampled directly so the first edge sees no history
  AST_RESET_CLEAR: assert property (@(posedge mclk)
    reset |=> port_e_direction_low == pfs_pkg::RST_DIR && pin_oe == 16'h0000)
    else $error("reset did not clear");
  AST_RESET_READ: assert property (@(posedge mclk)
    reset |=> readdata == 32'h0000_0000
    && port_e_function_select_pins_4_to_7 == pfs_pkg::RST_SEL
    && port_e_function_select_pins_8_to_11 == pfs_pkg::RST_SEL)
    else $error("reset left a select or read value");

  // Register bus
  AST_WRITE_DIR: assert property (@(posedge mclk) disable iff (reset)
    write && address == pfs_pkg::ADDR_DIR
    |=> port_e_direction_low == $past(writedata[15:0]))
    else $error("direction write lost");
  AST_WRITE_SEL_LO: assert property (@(posedge mclk) disable iff (reset)
    write && address == pfs_pkg::ADDR_SEL_LO
    |=> port_e_function_select_pins_4_to_7 == ($past(writedata[15:0]) & pfs_pkg::SEL_WMASK))
    else $error("low select write lost");
  AST_WRITE_SEL_HI: assert property (@(posedge mclk) disable iff (reset)
    write && address == pfs_pkg::ADDR_SEL_HI
    |=> port_e_function_select_pins_8_to_11 == ($past(writedata[15:0]) & pfs_pkg::SEL_WMASK))
    else $error("high select write lost");
  AST_READ_DIR: assert property (@(posedge mclk) disable iff (reset)
    read && waitrequest && address == pfs_pkg::ADDR_DIR
    |=> readdata == bus_word($past(port_e_direction_low)))
    else $error("direction read wrong");
  AST_READ_SEL: assert property (@(posedge mclk) disable iff (reset)
    read && waitrequest && address == pfs_pkg::ADDR_SEL_LO
    |=> readdata == bus_word($past(port_e_function_select_pins_4_to_7)))
    else $error("select read wrong");
  AST_READ_PINS: assert property (@(posedge mclk) disable iff (reset)
    read && waitrequest && address == pfs_pkg::ADDR_PIN_IN
    |=> readdata == bus_word($past(pin_sync)))
    else $error("pin level read wrong");
endmodule // pfs_port_e_mux

/* File: pfs_pkg.sv */
// Package for the port E low-half pin function select block.
// Assumes a 32-bit Avalon-MM register bus, one word per register.
package pfs_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_DIR = 4'h0;
  localparam logic [3:0] ADDR_SEL_LO = 4'h4;
  localparam logic [3:0] ADDR_SEL_HI = 4'h8;
  localparam logic [3:0] ADDR_PIN_IN = 4'hc;
  // Reset values
  localparam logic [15:0] RST_DIR = 16'h0000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  // Function code field layout
  localparam int FIELD_W = 3;
  localparam int FIELD_STRIDE = 4;
  localparam logic [15:0] SEL_WMASK = 16'h7777;
  // Function codes
  localparam logic [2:0] FN_PORT = 3'h0;
  localparam logic [2:0] FN_TX = 3'h2;
  localparam logic [2:0] FN_RX = 3'h3;
  // Field positions of the serial pins
  localparam int TX_PIN = 5;
  localparam int RX_PIN = 11;
  localparam int TX_FIELD_LSB = 4;
  localparam int RX_FIELD_LSB = 12;

  typedef struct packed {
    logic [15:0] out_data;
    logic [15:0] out_en;
  } pfs_drive_s;
endpackage

/* File: pfs_pin_model.sv */
// Pin stand-in: the outside world drives every pin that the design leaves free.
// Assumes ext_lvl comes from the bench and changes only after a clock edge.
`timescale 1ns/100ps
module pfs_pin_model
(
  // Pin sides
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_lvl,
  output logic [15:0] pin_lvl
);
  assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // pfs_pin_model

/* File: pfs_port_e_mux_test.sv */
// Self-checking bench for the port E pin function select block.
// Assumes the pin model resolves the pins; tx stands in for the serial unit.
`timescale 1ns/100ps
module pfs_port_e_mux_test;
  logic mclk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, tx = 1'b0, wr, rx;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic [15:0] pod = 16'h3c3c, ext = 16'h0ff0, lvl, po, oe, sy;
  int error_cnt = 0, n_tests = 0;
  always #25 mclk = ~mclk;
  pfs_port_e_mux dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(wr),
    .port_out_data(pod), .port_in_data(sy), .serial_transmit_line(tx),
    .serial_receive_line(rx), .pin_in(lvl), .pin_out(po), .pin_oe(oe));
  pfs_pin_model pins (.pin_out(po), .pin_oe(oe), .ext_lvl(ext), .pin_lvl(lvl));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    error_cnt += (s !== e);
    if (s !== e)
      $display("unexpected at %0t: got %h expected %h", $time, s, e);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= ~w;
    writedata <= {16'h0, d};
    @(posedge mclk);
    while (wr !== 1'b0)
      @(posedge mclk);
    if (!w)
      chk(readdata, {16'h0, d});
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic t_port;
    bus(1'b0, 4'h4, 16'h0);
    chk({oe, 15'h0, rx}, 32'h1);
    bus(1'b1, 4'h0, 16'ha5a5);
    repeat (3) @(posedge mclk);
    chk({oe, po & oe}, 32'ha5a52424);
    chk(sy, 16'h2e74);
    bus(1'b0, 4'hc, 16'h2e74);
    bus(1'b1, 4'h6, 16'hffff);
    bus(1'b0, 4'h6, 16'h0);
    bus(1'b0, 4'h0, 16'ha5a5);
  endtask
  task automatic t_tx;
    bus(1'b1, 4'h4, 16'hffff);
    bus(1'b0, 4'h4, 16'h7777);
    chk(po[5], 1'b1);
    bus(1'b1, 4'h4, 16'h0020);
    @(posedge mclk);
    chk({oe[5], po[5]}, 2'b10);
    tx <= 1'b1;
    pod <= 16'h0;
    @(posedge mclk);
    chk(po[5], 1'b1);
  endtask
  task automatic t_rx;
    ext <= 16'h0;
    bus(1'b1, 4'h8, 16'hf000);
    bus(1'b0, 4'h8, 16'h7000);
    chk(rx, 1'b1);
    bus(1'b1, 4'h8, 16'h3000);
    repeat (3) @(posedge mclk);
    chk({oe[11], rx}, 2'b00);
    bus(1'b0, 4'h8, 16'h3000);
    bus(1'b1, 4'h0, 16'h0800);
    @(posedge mclk);
    chk({oe[11], rx}, 2'b11);
  endtask
  task automatic t_reset;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({oe, 15'h0, rx}, 32'h1);
    bus(1'b0, 4'h0, 16'h0);
    bus(1'b0, 4'h4, 16'h0);
    bus(1'b0, 4'h8, 16'h0);
  endtask
  task automatic summarize(input int late);
    error_cnt += late;
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial #20us summarize(1);
  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_port();
    t_tx();
    t_rx();
    t_reset();
    summarize(0);
  end
endmodule // pfs_port_e_mux_test
